/* File: rtl/rprp_consts.vh */
// Constants for the reference picture remap parser
`ifndef RPRP_CONSTS_VH
`define RPRP_CONSTS_VH

// Register byte offsets
`define RPRP_ADR_CTRL 8'h00
`define RPRP_ADR_STATUS 8'h04
`define RPRP_ADR_SLICE 8'h08
`define RPRP_ADR_MB 8'h0C
`define RPRP_ADR_MAXLT 8'h10
`define RPRP_ADR_LASTPN 8'h14
`define RPRP_ADR_ST_BASE 8'h20
`define RPRP_ADR_LT_BASE 8'h40
`define RPRP_ADR_LIST_BASE 8'h80

// Control register fields
`define RPRP_CTRL_SP 0
`define RPRP_CTRL_CABAC 1
`define RPRP_CTRL_TYPE_LO 2
`define RPRP_CTRL_TYPE_HI 3
`define RPRP_CTRL_STORED 4
`define RPRP_CTRL_START 8

// Status register fields
`define RPRP_ST_BUSY 0
`define RPRP_ST_DONE 1
`define RPRP_ST_EDUP 2
`define RPRP_ST_ESEQ 3
`define RPRP_ST_EMISS 4
`define RPRP_ST_EOPC 5
`define RPRP_ST_BTYPE 6
`define RPRP_ST_CNT_LO 8
`define RPRP_ST_CNT_HI 12

// Entry valid bit in buffer and list words; long-term bit in list words
`define RPRP_ENT_VALID 15
`define RPRP_ENT_LONG 14

// Picture types
`define RPRP_PIC_I 2'h0
`define RPRP_PIC_P 2'h1
`define RPRP_PIC_B 2'h2

// Remap opcodes
`define RPRP_OPC_NEG 16'h0000
`define RPRP_OPC_POS 16'h0001
`define RPRP_OPC_LT 16'h0002
`define RPRP_OPC_END 16'h0003

// Field widths and sizes
`define RPRP_PN_W 10
`define RPRP_QI_W 5
`define RPRP_PN_MODULUS 1024
`define RPRP_PN_ONE 10'h001
`define RPRP_ST_N 8
`define RPRP_LT_N 8
`define RPRP_LIST_N 16

// Reset values
`define RPRP_MAXLT_RST 4'h0
`define RPRP_BTYPE_SLIDING 1'b0

`endif

/* File: rtl/rprp_parser.v */
// Slice header parser building the remapped reference index order
`timescale 1ns/1ps
`include "rprp_consts.vh"
// Summary of operation
// - Slice step_a index is 5-bit, 0..31
// - Stored picture number advances by one, wrapping
// - Non-stored picture increments last stored number
// - Flag duplicate short-term picture number as error
// - Selection flag 0 absent, 1 present
// - Absent layer gives default order; slices isolated
// - Remap opcodes expected only in P/B
// - Read next opcode after each remap field
// - Short-term first, most recent to oldest
// - Long-term ascending index below maximum
// - Nth remap goes to index n-1
// - P/B picture: buffering type follows end opcode
// - Opcodes: 0 neg, 1 pos, 2 long, 3 end
// - Absolute difference is code number plus one
// - Prediction starts current, then last remapped
// - Long-term remap leaves prediction unchanged
// - SP step_a parsed only in SP frames
// - Macroblock count parsed only with CABAC
// - Maximum long-term index starts at zero
// - Buffering type 0 sliding, 1 adaptive
module rprp_parser (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire sym_valid_i,
  input wire [15:0] sym_data_i,
  output reg sym_ready_o,
  output reg slice_done_o,
  output reg [4:0] slice_step_a_index_o,
  output reg buffering_type_o
);

localparam [3:0] S_IDLE = 4'h0;
localparam [3:0] S_FMB = 4'h1;
localparam [3:0] S_SQP = 4'h2;
localparam [3:0] S_SPQ = 4'h3;
localparam [3:0] S_MBN = 4'h4;
localparam [3:0] S_PN = 4'h5;
localparam [3:0] S_REF_SELECT_LAYER_FLAG = 4'h6;
localparam [3:0] S_OPC = 4'h7;
localparam [3:0] S_DIFF = 4'h8;
localparam [3:0] S_LTIDX = 4'h9;
localparam [3:0] S_BTYPE = 4'hA;
localparam [3:0] S_BUILD = 4'hB;

// Modular distance back from the current picture; wrap falls out of 10-bit math
function [9:0] pn_dist;
  input [9:0] cur;
  input [9:0] pn;
  begin
    pn_dist = cur - pn;
  end
endfunction

function parse_state;
  input [3:0] s;
  begin
    parse_state = (s != S_IDLE) && (s != S_BUILD);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg [3:0] state_ff;
reg [3:0] nxt_state;
reg [4:0] ctrl_ff;
reg [3:0] maxlt_ff;
reg [10:0] st_ff [0:7];
reg [7:0] lt_valid_ff;
reg [7:0] st_used_ff;
reg [7:0] lt_used_ff;
reg [10:0] list_ff [0:15];
reg [4:0] list_cnt_ff;
reg [9:0] pn_ff;
reg [9:0] last_pn_ff;
reg have_ref_ff;
reg [9:0] pred_ff;
reg [15:0] first_mb_ff;
reg [15:0] mb_cnt_ff;
reg [4:0] sp_qi_ff;
reg [1:0] opc_ff;
reg [5:0] flags_ff;
reg [5:0] set_flags;
reg [5:0] clr_flags;

wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
wire take = sym_valid_i & sym_ready_o;
wire [1:0] pic_type = ctrl_ff[`RPRP_CTRL_TYPE_HI:`RPRP_CTRL_TYPE_LO];
wire start = wb_wr & (wb_adr_i == `RPRP_ADR_CTRL) & wb_dat_i[`RPRP_CTRL_START];
wire [9:0] diff_abs = sym_data_i[9:0] + `RPRP_PN_ONE;
wire [9:0] tgt = (opc_ff == 2'h0) ? pred_ff - diff_abs : pred_ff + diff_abs;
wire list_full = list_cnt_ff[4];

////////////////////////////////////////////////////////////////////////////////
// Searches over the small picture buffer
reg hit;
reg [2:0] hit_idx;
reg dup;
reg st_found;
reg [2:0] st_best;
reg [9:0] st_bd;
reg lt_found;
reg [2:0] lt_best;
integer i, j;

always @*
begin
  hit = 1'b0;
  hit_idx = 3'h0;
  dup = 1'b0;
  st_found = 1'b0;
  st_best = 3'h0;
  st_bd = 10'h3FF;
  lt_found = 1'b0;
  lt_best = 3'h0;
  for (i = 0; i < `RPRP_ST_N; i = i + 1)
  begin
    if (st_ff[i][10] && (st_ff[i][9:0] == sym_data_i[9:0]))
      dup = 1'b1;
    if (!hit && st_ff[i][10] && !st_used_ff[i] && (st_ff[i][9:0] == tgt))
    begin
      hit = 1'b1;
      hit_idx = i[2:0];
    end
    if (st_ff[i][10] && !st_used_ff[i] && (st_ff[i][9:0] != pn_ff) &&
        (!st_found || (pn_dist(pn_ff, st_ff[i][9:0]) < st_bd)))
    begin
      st_found = 1'b1;
      st_best = i[2:0];
      st_bd = pn_dist(pn_ff, st_ff[i][9:0]);
    end
  end
  // Downward scan leaves the smallest eligible long-term index
  for (i = `RPRP_LT_N - 1; i >= 0; i = i - 1)
  begin
    if (lt_valid_ff[i] && !lt_used_ff[i] && ({1'b0, i[2:0]} < maxlt_ff))
    begin
      lt_found = 1'b1;
      lt_best = i[2:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Header sequencer
always @*
begin
  nxt_state = state_ff;
  case (state_ff)
    S_IDLE:
      if (start)
        nxt_state = S_FMB;
    S_FMB:
      if (take)
        nxt_state = S_SQP;
    S_SQP:
      if (take)
      begin
        if (ctrl_ff[`RPRP_CTRL_SP])
          nxt_state = S_SPQ;
        else if (ctrl_ff[`RPRP_CTRL_CABAC])
          nxt_state = S_MBN;
        else
          nxt_state = S_PN;
      end
    S_SPQ:
      if (take)
        nxt_state = ctrl_ff[`RPRP_CTRL_CABAC] ? S_MBN : S_PN;
    S_MBN:
      if (take)
        nxt_state = S_PN;
    S_PN:
      if (take)
        nxt_state = S_REF_SELECT_LAYER_FLAG;
    S_REF_SELECT_LAYER_FLAG:
      if (take)
      begin
        if (sym_data_i[0] == 1'b0)
          nxt_state = S_BUILD;
        else if (pic_type == `RPRP_PIC_I)
          nxt_state = S_BTYPE;
        else
          nxt_state = S_OPC;
      end
    S_OPC:
      if (take)
      begin
        case (sym_data_i)
          `RPRP_OPC_NEG: nxt_state = S_DIFF;
          `RPRP_OPC_POS: nxt_state = S_DIFF;
          `RPRP_OPC_LT: nxt_state = S_LTIDX;
          `RPRP_OPC_END: nxt_state = S_BTYPE;
          default: nxt_state = S_BUILD;
        endcase
      end
    S_DIFF:
      if (take)
        nxt_state = S_OPC;
    S_LTIDX:
      if (take)
        nxt_state = S_OPC;
    S_BTYPE:
      if (take)
        nxt_state = S_BUILD;
    S_BUILD:
      if (list_full || (!st_found && !lt_found))
        nxt_state = S_IDLE;
    default:
      nxt_state = S_IDLE;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// Sticky flags: a set in the same cycle as its clear wins
always @*
begin
  set_flags = 6'h00;
  clr_flags = 6'h00;
  if (wb_wr && (wb_adr_i == `RPRP_ADR_STATUS))
    clr_flags = wb_dat_i[5:0];
  clr_flags[`RPRP_ST_BUSY] = 1'b0;
  if ((state_ff == S_BUILD) && (nxt_state == S_IDLE))
    set_flags[`RPRP_ST_DONE] = 1'b1;
  if (take && (state_ff == S_PN))
  begin
    set_flags[`RPRP_ST_EDUP] = dup;
    // Both stored and non-stored pictures follow the last stored one
    set_flags[`RPRP_ST_ESEQ] = have_ref_ff &&
                               (sym_data_i[9:0] != last_pn_ff + `RPRP_PN_ONE);
  end
  if (take && (state_ff == S_DIFF) && (!hit || list_full))
    set_flags[`RPRP_ST_EMISS] = 1'b1;
  if (take && (state_ff == S_LTIDX) &&
      ((sym_data_i[15:3] != 13'h0000) || ({1'b0, sym_data_i[2:0]} >= maxlt_ff) ||
       !lt_valid_ff[sym_data_i[2:0]] || lt_used_ff[sym_data_i[2:0]] || list_full))
    set_flags[`RPRP_ST_EMISS] = 1'b1;
  if (take && (state_ff == S_OPC) && (sym_data_i > `RPRP_OPC_END))
    set_flags[`RPRP_ST_EOPC] = 1'b1;
  set_flags[`RPRP_ST_BUSY] = 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i)
begin
  if (rst_i)
  begin
    state_ff <= S_IDLE;
    ctrl_ff <= 5'h00;
    maxlt_ff <= `RPRP_MAXLT_RST;
    lt_valid_ff <= 8'h00;
    st_used_ff <= 8'h00;
    lt_used_ff <= 8'h00;
    list_cnt_ff <= 5'h00;
    pn_ff <= 10'h000;
    last_pn_ff <= 10'h000;
    have_ref_ff <= 1'b0;
    pred_ff <= 10'h000;
    first_mb_ff <= 16'h0000;
    mb_cnt_ff <= 16'h0000;
    sp_qi_ff <= 5'h00;
    opc_ff <= 2'h0;
    flags_ff <= 6'h00;
    sym_ready_o <= 1'b0;
    slice_done_o <= 1'b0;
    slice_step_a_index_o <= 5'h00;
    buffering_type_o <= `RPRP_BTYPE_SLIDING;
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
    for (j = 0; j < `RPRP_ST_N; j = j + 1)
      st_ff[j] <= 11'h000;
    for (j = 0; j < `RPRP_LIST_N; j = j + 1)
      list_ff[j] <= 11'h000;
  end
  else
  begin
    state_ff <= nxt_state;
    sym_ready_o <= parse_state(nxt_state);
    slice_done_o <= set_flags[`RPRP_ST_DONE];
    flags_ff <= (flags_ff & ~clr_flags) | set_flags;
    flags_ff[`RPRP_ST_BUSY] <= (nxt_state != S_IDLE);
    // Register writes
    if (wb_wr)
    begin
      if (wb_adr_i == `RPRP_ADR_CTRL)
        ctrl_ff <= wb_dat_i[4:0];
      if (wb_adr_i == `RPRP_ADR_MAXLT)
        maxlt_ff <= (wb_dat_i[3:0] > 4'h8) ? 4'h8 : wb_dat_i[3:0];
      if (wb_adr_i == `RPRP_ADR_LASTPN)
      begin
        last_pn_ff <= wb_dat_i[9:0];
        have_ref_ff <= wb_dat_i[`RPRP_ENT_VALID];
      end
      if (wb_adr_i[7:5] == 3'h1)
        st_ff[wb_adr_i[4:2]] <= {wb_dat_i[`RPRP_ENT_VALID], wb_dat_i[9:0]};
      if (wb_adr_i[7:5] == 3'h2)
        lt_valid_ff[wb_adr_i[4:2]] <= wb_dat_i[`RPRP_ENT_VALID];
    end
    // Every slice starts from a clean remap state
    if (start && (state_ff == S_IDLE))
    begin
      st_used_ff <= 8'h00;
      lt_used_ff <= 8'h00;
      list_cnt_ff <= 5'h00;
    end
    if (take)
    begin
      case (state_ff)
        S_FMB: first_mb_ff <= sym_data_i;
        S_SQP: slice_step_a_index_o <= sym_data_i[4:0];
        S_SPQ: sp_qi_ff <= sym_data_i[4:0];
        S_MBN: mb_cnt_ff <= sym_data_i;
        S_PN:
        begin
          pn_ff <= sym_data_i[9:0];
          pred_ff <= sym_data_i[9:0];
        end
        S_OPC: opc_ff <= sym_data_i[1:0];
        S_DIFF:
          if (hit && !list_full)
          begin
            pred_ff <= tgt;
            st_used_ff[hit_idx] <= 1'b1;
            list_ff[list_cnt_ff[3:0]] <= {1'b0, tgt};
            list_cnt_ff <= list_cnt_ff + 5'h01;
          end
        S_LTIDX:
          // Prediction untouched here
          if (!set_flags[`RPRP_ST_EMISS])
          begin
            lt_used_ff[sym_data_i[2:0]] <= 1'b1;
            list_ff[list_cnt_ff[3:0]] <= {1'b1, 7'h00, sym_data_i[2:0]};
            list_cnt_ff <= list_cnt_ff + 5'h01;
          end
        S_BTYPE: buffering_type_o <= sym_data_i[0];
        default: opc_ff <= opc_ff;
      endcase
    end
    // Unmoved pictures follow in default order, one per cycle
    if ((state_ff == S_BUILD) && !list_full)
    begin
      if (st_found)
      begin
        st_used_ff[st_best] <= 1'b1;
        list_ff[list_cnt_ff[3:0]] <= {1'b0, st_ff[st_best][9:0]};
        list_cnt_ff <= list_cnt_ff + 5'h01;
      end
      else if (lt_found)
      begin
        lt_used_ff[lt_best] <= 1'b1;
        list_ff[list_cnt_ff[3:0]] <= {1'b1, 7'h00, lt_best};
        list_cnt_ff <= list_cnt_ff + 5'h01;
      end
    end
    if (set_flags[`RPRP_ST_DONE] && ctrl_ff[`RPRP_CTRL_STORED])
    begin
      last_pn_ff <= pn_ff;
      have_ref_ff <= 1'b1;
    end
    // Wishbone answer one cycle after the request
    wb_ack_o <= wb_req;
    wb_dat_o <= 32'h00000000;
    if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i[7:5])
        3'h0:
          case (wb_adr_i)
            `RPRP_ADR_CTRL: wb_dat_o <= {27'h0000000, ctrl_ff};
            `RPRP_ADR_STATUS: wb_dat_o <= {19'h00000, list_cnt_ff, 1'b0,
                                           buffering_type_o, flags_ff};
            `RPRP_ADR_SLICE: wb_dat_o <= {6'h00, pn_ff, 3'h0, sp_qi_ff, 3'h0,
                                          slice_step_a_index_o};
            `RPRP_ADR_MB: wb_dat_o <= {mb_cnt_ff, first_mb_ff};
            `RPRP_ADR_MAXLT: wb_dat_o <= {28'h0000000, maxlt_ff};
            `RPRP_ADR_LASTPN: wb_dat_o <= {16'h0000, have_ref_ff, 5'h00, last_pn_ff};
            default: wb_dat_o <= 32'h00000000;
          endcase
        3'h1: wb_dat_o <= {16'h0000, st_ff[wb_adr_i[4:2]][10], 5'h00,
                           st_ff[wb_adr_i[4:2]][9:0]};
        3'h2: wb_dat_o <= {16'h0000, lt_valid_ff[wb_adr_i[4:2]], 15'h0000};
        3'h4, 3'h5: wb_dat_o <= {16'h0000, ({1'b0, wb_adr_i[5:2]} < list_cnt_ff),
                                 list_ff[wb_adr_i[5:2]][10], 4'h0,
                                 list_ff[wb_adr_i[5:2]][9:0]};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
end

endmodule

/* File: verification/rprp_enc_model.sv */
// Encoder-side source of slice header code numbers
`timescale 1ns/1ps
module rprp_enc_model (
  input wire clk_i,
  input wire rst_i,
  input wire slow_i,
  input wire sym_ready_i,
  output logic sym_valid_o,
  output logic [15:0] sym_data_o
);
  logic [15:0] q[$];
  ////////////////////////////////////////
  // Elements leave in bitstream order; a slow encoder idles between them
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sym_valid_o <= 1'b0;
      sym_data_o <= 16'h0000;
    end
    else if (sym_valid_o && sym_ready_i)
    begin
      void'(q.pop_front());
      if (q.size() != 0 && !slow_i)
        sym_data_o <= q[0];
      else
      begin
        sym_valid_o <= 1'b0;
        // Inverted so a stale word never looks fresh
        sym_data_o <= ~sym_data_o;
      end
    end
    else if (!sym_valid_o && q.size() != 0)
    begin
      sym_valid_o <= 1'b1;
      sym_data_o <= q[0];
    end
  end
endmodule

/* File: verification/rprp_parser_asserts.sv */
// Port-level checks for the remap parser
`timescale 1ns/1ps
module rprp_parser_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire sym_valid_i,
  input wire [15:0] sym_data_i,
  input wire sym_ready_o,
  input wire slice_done_o,
  input wire [4:0] slice_step_a_index_o,
  input wire buffering_type_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Start is taken at the request edge, one cycle before ack shows
  wire start_wr = req && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0] && wb_dat_i[8];
  ////////////////////////////////////////
  property p_ack_next; req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_ack_cause; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside answer");
  property p_start; $rose(sym_ready_o) |-> $past(start_wr); endproperty
  a_start: assert property (p_start) else $error("parse began without start");
  property p_build; $fell(sym_ready_o) |-> ##[1:20] slice_done_o; endproperty
  a_build: assert property (p_build) else $error("list build too long");
  property p_done_once; slice_done_o |=> !slice_done_o; endproperty
  a_done_once: assert property (p_done_once) else $error("done held");
  property p_done_idle; slice_done_o |-> !sym_ready_o; endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while parsing");
  property p_ready_hold; sym_ready_o && !sym_valid_i |=> sym_ready_o; endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready fell without element");
  c_done: cover property (slice_done_o);
  c_end_opc: cover property (sym_valid_i && sym_ready_o && sym_data_i == 16'h0003);
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule
bind rprp_parser rprp_parser_asserts rprp_parser_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sym_valid_i(sym_valid_i), .sym_data_i(sym_data_i), .sym_ready_o(sym_ready_o),
  .slice_done_o(slice_done_o), .slice_step_a_index_o(slice_step_a_index_o),
  .buffering_type_o(buffering_type_o));

/* File: verification/test_rprp_parser.sv */
// Directed bench for the remap parser
`timescale 1ns/1ps
`include "rprp_consts.vh"
module test_rprp_parser;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wd = 32'h0;
  logic slow = 1'b0;
  logic [31:0] r;
  wire [31:0] rdw;
  wire ack, vld, rdy, done, btype;
  wire [15:0] sym;
  wire [4:0] qi;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  always #25 clk_i = ~clk_i;
  rprp_parser rprp_parser_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdw), .wb_ack_o(ack),
    .sym_valid_i(vld), .sym_data_i(sym), .sym_ready_o(rdy), .slice_done_o(done),
    .slice_step_a_index_o(qi), .buffering_type_o(btype));
  rprp_enc_model rprp_enc_model_i (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .sym_ready_i(rdy), .sym_valid_o(vld), .sym_data_o(sym));
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= s;
    // Only ack or the bench timeout ends this wait
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    r = rdw;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(nm, e, r & m);
  endtask
  task automatic slice(input logic [31:0] ctrl, input logic [15:0] el[$]);
    int n;
    n = 0;
    foreach (el[k])
      rprp_enc_model_i.q.push_back(el[k]);
    wr(`RPRP_ADR_CTRL, ctrl | 32'h100);
    while (done !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("slice_done_o", 32'h1, 32'(done));
  endtask
  task automatic list(input logic [31:0] ex[6]);
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b0, `RPRP_ADR_LIST_BASE + 8'(4 * i), 32'h0, 4'hF);
      chk("ref_list", ex[i], r);
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(`RPRP_ADR_MAXLT, 32'hF, 32'h0, "maxlt");
    rdc(`RPRP_ADR_STATUS, 32'hFFFFFFFF, 32'h0, "status");
    rdc(8'hFC, 32'hFFFFFFFF, 32'h0, "unmapped");
    wr(`RPRP_ADR_ST_BASE, 32'h812C);
    wr(`RPRP_ADR_ST_BASE + 8'h04, 32'h812E);
    wr(`RPRP_ADR_ST_BASE + 8'h08, 32'h812F);
    wr(`RPRP_ADR_LT_BASE, 32'h8000);
    wr(`RPRP_ADR_LT_BASE + 8'h0C, 32'h8000);
    wr(`RPRP_ADR_MAXLT, 32'h4);
    xfer(1'b1, `RPRP_ADR_MAXLT, 32'h7, 4'hE);
    rdc(`RPRP_ADR_MAXLT, 32'hF, 32'h4, "maxlt");
    wr(`RPRP_ADR_LASTPN, 32'h812F);
    slow <= 1'b1;
    // Down 2, long index 3, then up 1 from the last short-term target
    slice(32'h4, '{16'h5, 16'h1F, 16'h130, 16'h1, 16'h0, 16'h1, 16'h2, 16'h3, 16'h1, 16'h0,
      16'h3, 16'h1});
    chk("step_a", 32'h1F, 32'(qi));
    chk("btype", 32'h1, 32'(btype));
    list('{32'h812E, 32'hC003, 32'h812F, 32'h812C, 32'hC000, 32'h0});
    rdc(`RPRP_ADR_STATUS, 32'hFFFFFFFF, 32'h542, "status");
    wr(`RPRP_ADR_STATUS, 32'h3E);
    slow <= 1'b0;
    slice(32'h4, '{16'h5, 16'h3, 16'h130, 16'h0});
    list('{32'h812F, 32'h812E, 32'h812C, 32'hC000, 32'hC003, 32'h0});
    rdc(`RPRP_ADR_STATUS, 32'h1F3F, 32'h502, "status");
    wr(`RPRP_ADR_STATUS, 32'h3E);
    wr(`RPRP_ADR_ST_BASE + 8'h0C, 32'h83FF);
    wr(`RPRP_ADR_ST_BASE + 8'h10, 32'h8001);
    // Current number 1 repeats a buffered one and breaks the sequence; target wraps to 1023
    slice(32'h4, '{16'h5, 16'h3, 16'h1, 16'h1, 16'h0, 16'h1, 16'h3, 16'h0});
    list('{32'h83FF, 32'h812F, 32'h812E, 32'h812C, 32'hC000, 32'hC003});
    rdc(`RPRP_ADR_STATUS, 32'h1F3F, 32'h60E, "status");
    chk("btype", 32'h0, 32'(btype));
    wr(`RPRP_ADR_STATUS, 32'h3E);
    slice(32'h13, '{16'h7, 16'h0, 16'h15, 16'h63, 16'h130, 16'h1, 16'h1});
    rdc(`RPRP_ADR_SLICE, 32'hFFFFFFFF, 32'h01301500, "slice");
    rdc(`RPRP_ADR_MB, 32'hFFFFFFFF, 32'h00630007, "mb");
    rdc(`RPRP_ADR_LASTPN, 32'h83FF, 32'h8130, "lastpn");
    chk("btype", 32'h1, 32'(btype));
    wr(`RPRP_ADR_STATUS, 32'h3E);
    slice(32'h4, '{16'h5, 16'h3, 16'h131, 16'h1, 16'h5});
    rdc(`RPRP_ADR_STATUS, 32'h3E, 32'h22, "status");
    wr(`RPRP_ADR_STATUS, 32'h3E);
    // B picture, CABAC only: long index 3 moves first, a difference to an absent picture misses
    slice(32'hA, '{16'h5, 16'h3, 16'h10, 16'h131, 16'h1, 16'h2, 16'h3, 16'h0, 16'h9, 16'h3,
      16'h0});
    list('{32'hC003, 32'h812F, 32'h812E, 32'h812C, 32'h8001, 32'h83FF});
    rdc(`RPRP_ADR_STATUS, 32'h1F3F, 32'h712, "status");
    rdc(`RPRP_ADR_MB, 32'hFFFFFFFF, 32'h00100005, "mb");
    tally_and_finish();
  end
endmodule
